/* hw/pdp_ctrl.sv */
// How it works
// RULE_01: low disconnect-enable bits switch supervision per channel, reset 1; upper bits plain.
// RULE_02: supervised channel below threshold runs the timer; expiry turns channel off.
// RULE_03: disconnect-timer turn-off sets that channel's disconnect fault flag.
// RULE_04: timer clears after 3 ms above threshold and never counts below zero.
// RULE_05: 4-pair single-signature port: either enable bit, expiry turns both channels off.
// RULE_06: power-on command re-powers a channel only if discovery valid and allocation enough.
// RULE_07: at turn-on the disconnect threshold comes from four-pair bits and assigned class.
// RULE_08: during cool-down, detect and class starts for that channel are held off.
// RULE_09: after cool-down, cycles restart by themselves when enable bits are still set.
// RULE_10: detect/class register: class enables bits 7-4, detect enables 3-0, reset 0.
// RULE_11: manual mode runs one cycle per set bit and clears the bit when it finishes.
// RULE_12: a turn-off command clears the channel's detect and class enable bits.
// RULE_13: semiauto repeats discovery while unpowered; class only after valid detection.
// RULE_14: in semiauto the restart command sets enable bits like a register write.
// RULE_15: 4-pair ports in semiauto/auto need all four enable bits before discovery.
// RULE_16: host should finish a port reset before enabling discovery in manual mode.
// RULE_17: with single-bit priority, priority bit 1 powers channel off on fast shutdown.
// RULE_18: each priority bit acts on its own channel, also inside a 4-pair port.
// RULE_19: cut-disable bit stops a 2-pair power-cut fault alone from turning channel off.
// RULE_20: with cut disabled the power-cut flag still rises after the overload time.
// RULE_21: any change of a cut-disable bit restarts that channel's overload timer.
// RULE_22: host keeps priority bits clear while multi-bit priority is selected.
// RULE_23: fast-shutdown turn-off clears status and enables but leaves cool-down alone.
`timescale 1ns/100ps
module pdp_ctrl import pdp_pkg::*; #(
  parameter int DISCONNECT_CYC = PDP_DISCONNECT_CYC,
  parameter int ABOVE_HOLD_CYC = PDP_ABOVE_HOLD_CYC,
  parameter int OVERLOAD_CYC = PDP_OVERLOAD_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // command registers, one byte per access
  input wire pdp_cmd_s cmd,
  output logic [7:0] rd_data,
  // port configuration
  input wire logic [1:0] four_pair_wired_bits,
  input wire logic [1:0] single_signature,
  input wire logic multibit_priority_select,
  input wire logic fast_shutdown_input,
  // per-channel events from host commands
  input wire logic [3:0] power_on_command,
  input wire logic [3:0] power_off_command,
  input wire logic [3:0] restart_detect,
  input wire logic [3:0] restart_class,
  input wire logic [3:0] fault_clear,
  // per-channel status from the analog front end
  input wire pdp_chan_s [3:0] chan,
  // per-channel results
  output logic [3:0] channel_off,
  output logic [3:0] power_on_grant,
  output logic [3:0] detect_start,
  output logic [3:0] class_start,
  output logic [3:0] disconnect_fault_flag,
  output logic [3:0] power_cut_fault_flag,
  output logic [7:0] disconnect_threshold_bits
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic is_write(pdp_cmd_s c, logic [7:0] a);
    return c.valid && c.write && (c.addr == a);
  endfunction

  function automatic logic [1:0] threshold_code(logic fp, logic [3:0] cls);
    if (!fp) begin
      return PDP_THRESH_2PAIR;
    end
    return (cls >= PDP_HIGH_CLASS) ? PDP_THRESH_4PAIR_HIGH : PDP_THRESH_4PAIR_LOW;
  endfunction

  function automatic int partner(int i);
    return i ^ 1;
  endfunction

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  logic [7:0] disc_en_q;
  logic [7:0] dce_q;
  logic [7:0] dce_d;
  logic [7:0] prio_cut_q;
  logic [3:0] cut_last_q;
  logic [3:0] powered_last_q;
  logic [1:0] oss_sync_q;
  logic [3:0] clr_det;
  logic [3:0] clr_cls;
  logic [3:0] disc_exp;
  logic [3:0] disc_off;
  logic [3:0] oss_off;
  logic [3:0] ovld_to;
  logic [3:0] cut_off;
  logic [3:0] supervise;
  logic [3:0] det_go;
  logic [3:0] cls_go;
  logic oss_active;
  pdp_dc_state_e [3:0] dc_state_q;

  // ----------------------------------------------------------------
  // fast shutdown pin synchroniser
  // ----------------------------------------------------------------
  // two stages; only the second stage feeds logic
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      oss_sync_q <= 2'h0;
    end else begin
      oss_sync_q <= {oss_sync_q[0], fast_shutdown_input};
    end
  end

  // multi-bit priority takes over shutdown; priority bits are then ignored here
  assign oss_active = oss_sync_q[1] && !multibit_priority_select; // see RULE_17 see RULE_22

  // ----------------------------------------------------------------
  // register writes and reads
  // ----------------------------------------------------------------
  // disconnect enable register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      disc_en_q <= PDP_DISCONNECT_ENABLE_RST; // see RULE_01
    end else if (is_write(cmd, PDP_REG_DISCONNECT_ENABLE)) begin
      disc_en_q <= cmd.wdata; // see RULE_01
    end
  end

  // priority and cut-disable register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prio_cut_q <= PDP_SHUTDOWN_PRIORITY_CUT_DISABLE_RST;
      cut_last_q <= 4'h0;
    end else begin
      cut_last_q <= prio_cut_q[PDP_LOW_LSB +: 4];
      if (is_write(cmd, PDP_REG_SHUTDOWN_PRIORITY_CUT_DISABLE)) begin
        prio_cut_q <= cmd.wdata;
      end
    end
  end

  // detect/class enable: hardware clears, but a write or restart in the same cycle wins
  always_comb begin
    dce_d = dce_q & ~{clr_cls, clr_det};
    if (is_write(cmd, PDP_REG_DETECT_CLASS_ENABLE)) begin
      dce_d = cmd.wdata; // see RULE_10
    end
    for (int i = 0; i < PDP_CHANNELS; i++) begin
      if (chan[i].mode == PDP_MODE_SEMIAUTO) begin
        dce_d[PDP_HIGH_LSB + i] = dce_d[PDP_HIGH_LSB + i] | restart_class[i]; // see RULE_14
        dce_d[PDP_LOW_LSB + i] = dce_d[PDP_LOW_LSB + i] | restart_detect[i]; // see RULE_14
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dce_q <= PDP_DETECT_CLASS_ENABLE_RST; // see RULE_10
    end else begin
      dce_q <= dce_d;
    end
  end

  // read data is registered; unmapped offsets read zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_data <= 8'h00;
    end else if (cmd.valid && !cmd.write) begin
      case (cmd.addr)
        PDP_REG_DISCONNECT_ENABLE: rd_data <= disc_en_q;
        PDP_REG_DETECT_CLASS_ENABLE: rd_data <= dce_q;
        PDP_REG_SHUTDOWN_PRIORITY_CUT_DISABLE: rd_data <= prio_cut_q;
        default: rd_data <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // per-channel supervision and shutdown
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < PDP_CHANNELS; g++) begin : gen_chan
      localparam int P = g / 2;
      logic single4;
      assign single4 = four_pair_wired_bits[P] && single_signature[P];

      // a single-signature 4-pair port is supervised if either channel asks
      assign supervise[g] = single4 ? (disc_en_q[PDP_LOW_LSB + g] | disc_en_q[PDP_LOW_LSB + partner(g)])
                                    : disc_en_q[PDP_LOW_LSB + g]; // see RULE_01 see RULE_05

      pdp_disc_timer #(
        .DISCONNECT_TIMER_CYC(DISCONNECT_CYC),
        .HOLD_CYC(ABOVE_HOLD_CYC)
      ) u_disc (
        .clk(clk),
        .reset(reset),
        .enable(supervise[g] && chan[g].powered), // see RULE_02
        .below(chan[g].below_threshold), // see RULE_04
        .clear(channel_off[g]),
        .expired(disc_exp[g])
      );

      // expiry on either channel of a single-signature port drops both
      assign disc_off[g] = disc_exp[g] | (single4 & disc_exp[partner(g)]); // see RULE_02 see RULE_05

      // each priority bit acts on its own channel only
      assign oss_off[g] = oss_active && prio_cut_q[PDP_HIGH_LSB + g] && chan[g].powered; // see RULE_17 see RULE_18

      pdp_ovld_timer #(
        .OVLD_CYC(OVERLOAD_CYC)
      ) u_ovld (
        .clk(clk),
        .reset(reset),
        .fault(chan[g].power_cut_fault && chan[g].powered),
        .restart(prio_cut_q[PDP_LOW_LSB + g] != cut_last_q[g]), // see RULE_21
        .timeout(ovld_to[g])
      );

      // cut disabled: the timeout still flags, but does not turn off
      assign cut_off[g] = ovld_to[g] && !prio_cut_q[PDP_LOW_LSB + g]; // see RULE_19
    end
  endgenerate

  // turn-off request: any cause, gated by the channel's power good
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      channel_off <= 4'h0;
    end else begin
      channel_off <= (disc_off | oss_off | cut_off) & {chan[3].powered, chan[2].powered,
                                                      chan[1].powered, chan[0].powered};
    end
  end

  // disconnect fault: set wins over host clear; shutdown clears it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      disconnect_fault_flag <= 4'h0;
    end else begin
      disconnect_fault_flag <= (disconnect_fault_flag & ~(fault_clear | oss_off)) | disc_off; // see RULE_03 see RULE_23
    end
  end

  // power-cut fault flag raised after the overload time, disabled or not
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      power_cut_fault_flag <= 4'h0;
    end else begin
      power_cut_fault_flag <= (power_cut_fault_flag & ~(fault_clear | oss_off)) | ovld_to; // see RULE_20 see RULE_23
    end
  end

  // ----------------------------------------------------------------
  // power-on and threshold capture
  // ----------------------------------------------------------------
  // re-power only when discovery still holds and the allocation covers the class
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      power_on_grant <= 4'h0;
    end else begin
      for (int i = 0; i < PDP_CHANNELS; i++) begin
        power_on_grant[i] <= power_on_command[i] && !chan[i].powered &&
                             chan[i].discovery_valid && chan[i].allocation_ok; // see RULE_06
      end
    end
  end

  // threshold is latched on the rising edge of power good
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      powered_last_q <= 4'h0;
      disconnect_threshold_bits <= 8'h00;
    end else begin
      for (int i = 0; i < PDP_CHANNELS; i++) begin
        powered_last_q[i] <= chan[i].powered;
        if (chan[i].powered && !powered_last_q[i]) begin
          disconnect_threshold_bits[2*i +: 2] <= threshold_code(four_pair_wired_bits[i/2],
                                                                chan[i].assigned_class); // see RULE_07
        end else if (oss_off[i]) begin
          disconnect_threshold_bits[2*i +: 2] <= PDP_THRESH_2PAIR; // see RULE_23
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // discovery sequencing
  // ----------------------------------------------------------------
  // start conditions; 4-pair ports in semiauto or auto need all four bits
  always_comb begin
    det_go = 4'h0;
    cls_go = 4'h0;
    for (int i = 0; i < PDP_CHANNELS; i++) begin
      if (chan[i].mode == PDP_MODE_MANUAL) begin
        det_go[i] = dce_q[PDP_LOW_LSB + i];
        cls_go[i] = dce_q[PDP_HIGH_LSB + i];
      end else if (chan[i].mode != PDP_MODE_OFF) begin
        if (four_pair_wired_bits[i/2]) begin
          det_go[i] = &{dce_q[PDP_LOW_LSB + i], dce_q[PDP_LOW_LSB + partner(i)],
                        dce_q[PDP_HIGH_LSB + i], dce_q[PDP_HIGH_LSB + partner(i)]}; // see RULE_15
        end else begin
          det_go[i] = dce_q[PDP_LOW_LSB + i]; // see RULE_13
        end
        cls_go[i] = det_go[i] && dce_q[PDP_HIGH_LSB + i];
      end
    end
  end

  // hardware clears of enable bits
  always_comb begin
    clr_det = power_off_command | oss_off; // see RULE_12 see RULE_23
    clr_cls = power_off_command | oss_off; // see RULE_12 see RULE_23
    for (int i = 0; i < PDP_CHANNELS; i++) begin
      if (chan[i].mode == PDP_MODE_MANUAL) begin
        if (dc_state_q[i] == PDP_DC_DETECT && chan[i].detect_done) begin
          clr_det[i] = 1'b1; // see RULE_11
        end
        if (dc_state_q[i] == PDP_DC_CLASS && chan[i].class_done) begin
          clr_cls[i] = 1'b1; // see RULE_11
        end
      end
    end
  end

  // per-channel sequencer; cool-down blocks starts, which resume on their own after it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dc_state_q <= '{default: PDP_DC_IDLE};
      detect_start <= 4'h0;
      class_start <= 4'h0;
    end else begin
      detect_start <= 4'h0;
      class_start <= 4'h0;
      for (int i = 0; i < PDP_CHANNELS; i++) begin
        case (dc_state_q[i])
          PDP_DC_IDLE: begin
            if (!chan[i].cooldown && !chan[i].powered && !oss_off[i] && !power_off_command[i]) begin // see RULE_08 see RULE_09
              if (det_go[i]) begin
                dc_state_q[i] <= PDP_DC_DETECT;
                detect_start[i] <= 1'b1;
              end else if (cls_go[i]) begin
                dc_state_q[i] <= PDP_DC_CLASS;
                class_start[i] <= 1'b1;
              end
            end
          end
          PDP_DC_DETECT: begin
            if (oss_off[i] || power_off_command[i]) begin
              dc_state_q[i] <= PDP_DC_IDLE;
            end else if (chan[i].detect_done) begin
              // class follows only a valid detection outside manual mode
              if (cls_go[i] && (chan[i].detect_valid || chan[i].mode == PDP_MODE_MANUAL)) begin // see RULE_13
                dc_state_q[i] <= PDP_DC_CLASS;
                class_start[i] <= 1'b1;
              end else begin
                dc_state_q[i] <= PDP_DC_IDLE;
              end
            end
          end
          PDP_DC_CLASS: begin
            if (chan[i].class_done || oss_off[i] || power_off_command[i]) begin
              dc_state_q[i] <= PDP_DC_IDLE;
            end
          end
          default: dc_state_q[i] <= PDP_DC_IDLE;
        endcase
      end
    end
  end

endmodule

/* inc/pdp_pkg.sv */
package pdp_pkg;

  // ----------------------------------------------------------------
  // command register offsets and layout
  // ----------------------------------------------------------------
  localparam logic [7:0] PDP_REG_DISCONNECT_ENABLE = 8'h13;
  localparam logic [7:0] PDP_REG_DETECT_CLASS_ENABLE = 8'h14;
  localparam logic [7:0] PDP_REG_SHUTDOWN_PRIORITY_CUT_DISABLE = 8'h15;
  localparam logic [7:0] PDP_DISCONNECT_ENABLE_RST = 8'h0f;
  localparam logic [7:0] PDP_DETECT_CLASS_ENABLE_RST = 8'h00;
  localparam logic [7:0] PDP_SHUTDOWN_PRIORITY_CUT_DISABLE_RST = 8'h00;
  localparam int PDP_LOW_LSB = 0;   // supervise, detect enable, cut disable
  localparam int PDP_HIGH_LSB = 4;  // class enable, shutdown priority
  localparam int PDP_CHANNELS = 4;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int PDP_CLK_HZ = 40_000_000;
  localparam int PDP_ABOVE_HOLD_MS = 3;
  localparam int PDP_ABOVE_HOLD_CYC = (PDP_ABOVE_HOLD_MS * PDP_CLK_HZ + 999) / 1000;
  localparam int PDP_DISCONNECT_MS = 300;
  localparam int PDP_DISCONNECT_CYC = (PDP_DISCONNECT_MS * PDP_CLK_HZ) / 1000;
  localparam int PDP_OVERLOAD_MS = 60;
  localparam int PDP_OVERLOAD_CYC = (PDP_OVERLOAD_MS * PDP_CLK_HZ) / 1000;
  localparam int PDP_CNT_W = 25;
  localparam logic [3:0] PDP_HIGH_CLASS = 4'h5;  // classes at or above use the 4-pair high threshold
  localparam logic [1:0] PDP_THRESH_2PAIR = 2'h0;
  localparam logic [1:0] PDP_THRESH_4PAIR_LOW = 2'h1;
  localparam logic [1:0] PDP_THRESH_4PAIR_HIGH = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PDP_MODE_OFF, PDP_MODE_MANUAL, PDP_MODE_SEMIAUTO, PDP_MODE_AUTO} pdp_mode_e;
  typedef enum logic [1:0] {PDP_DC_IDLE, PDP_DC_DETECT, PDP_DC_CLASS} pdp_dc_state_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pdp_cmd_s;

  typedef struct packed {
    pdp_mode_e mode;
    logic powered;
    logic below_threshold;
    logic cooldown;
    logic detect_done;
    logic detect_valid;
    logic class_done;
    logic power_cut_fault;
    logic discovery_valid;
    logic allocation_ok;
    logic [3:0] assigned_class;
  } pdp_chan_s;

endpackage

/* hw/pdp_disc_timer.sv */
`timescale 1ns/100ps
module pdp_disc_timer import pdp_pkg::*; #(
  parameter int DISCONNECT_TIMER_CYC = PDP_DISCONNECT_CYC,
  parameter int HOLD_CYC = PDP_ABOVE_HOLD_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // channel status
  input wire logic enable,
  input wire logic below,
  input wire logic clear,
  // expiry
  output logic expired
);
  logic [PDP_CNT_W-1:0] disconnect_timer_q;
  logic [PDP_CNT_W-1:0] above_q;

  // disconnect timer: counts up only, so it never goes below zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      disconnect_timer_q <= '0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (clear || !enable) begin
        disconnect_timer_q <= '0;
      end else if (above_q == PDP_CNT_W'(HOLD_CYC - 1)) begin
        disconnect_timer_q <= '0;
      end else if (below) begin
        if (disconnect_timer_q == PDP_CNT_W'(DISCONNECT_TIMER_CYC - 1)) begin
          disconnect_timer_q <= '0;
          expired <= 1'b1;
        end else begin
          disconnect_timer_q <= disconnect_timer_q + 1'b1;
        end
      end
    end
  end

  // above-threshold run length; a short excursion keeps the elapsed time
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      above_q <= '0;
    end else if (clear || below) begin
      above_q <= '0;
    end else if (above_q != PDP_CNT_W'(HOLD_CYC - 1)) begin
      above_q <= above_q + 1'b1;
    end
  end
endmodule

/* hw/pdp_ovld_timer.sv */
`timescale 1ns/100ps
module pdp_ovld_timer import pdp_pkg::*; #(
  parameter int OVLD_CYC = PDP_OVERLOAD_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // fault and restart
  input wire logic fault,
  input wire logic restart,
  // timeout
  output logic timeout
);
  logic [PDP_CNT_W-1:0] cnt_q;

  // overload timer runs while the fault persists, one timeout per episode
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q <= '0;
      timeout <= 1'b0;
    end else begin
      timeout <= 1'b0;
      if (restart || !fault) begin
        cnt_q <= '0;
      end else if (cnt_q == PDP_CNT_W'(OVLD_CYC - 1)) begin
        timeout <= 1'b1;
        cnt_q <= PDP_CNT_W'(OVLD_CYC);
      end else if (cnt_q != PDP_CNT_W'(OVLD_CYC)) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule

/* verification/pdp_host_model.sv */
`timescale 1ns/100ps
module pdp_host_model import pdp_pkg::*; (
  // clock
  input wire logic clk,
  // command channel
  output pdp_cmd_s cmd,
  input wire logic [7:0] rd_data
);
  // ----------------------------------------------------------------
  // byte access
  // ----------------------------------------------------------------
  initial cmd = '0;
  // no port reset in this slice; discovery enabled at once
  // raised after an edge, held over the taking edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    cmd <= '{valid: 1'b1, write: w, addr: a, wdata: d};
    @(posedge clk);
    cmd <= '0;
    #1 q = rd_data;
  endtask
endmodule

/* verification/pdp_ctrl_sva.sv */
`timescale 1ns/100ps
module pdp_ctrl_sva import pdp_pkg::*; #(
  parameter int DISCONNECT_CYC = PDP_DISCONNECT_CYC,
  parameter int ABOVE_HOLD_CYC = PDP_ABOVE_HOLD_CYC,
  parameter int OVERLOAD_CYC = PDP_OVERLOAD_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register access
  input wire pdp_cmd_s cmd,
  input wire logic [7:0] rd_data,
  // configuration
  input wire logic [1:0] four_pair_wired_bits,
  input wire logic [1:0] single_signature,
  // events and status
  input wire logic [3:0] power_on_command,
  input wire pdp_chan_s [3:0] chan,
  // results
  input wire logic [3:0] channel_off,
  input wire logic [3:0] power_on_grant,
  input wire logic [3:0] detect_start,
  input wire logic [3:0] class_start,
  input wire logic [3:0] disconnect_fault_flag,
  input wire logic [3:0] power_cut_fault_flag,
  input wire logic [7:0] disconnect_threshold_bits
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // --------------------
  // helper counters on channel 0
  // --------------------
  int above_q;
  int below_q;
  int cut_q;
  // above-threshold run
  always_ff @(posedge clk or posedge reset) begin
    if (reset) above_q <= 0;
    else above_q <= chan[0].below_threshold ? 0 : above_q + 1;
  end
  // below tally, slack of two for clear timing
  always_ff @(posedge clk or posedge reset) begin
    if (reset) below_q <= 0;
    else if (above_q >= ABOVE_HOLD_CYC) below_q <= 0;
    else if (chan[0].below_threshold) below_q <= below_q + 1;
  end
  // run of power-cut fault cycles
  always_ff @(posedge clk or posedge reset) begin
    if (reset) cut_q <= 0;
    else cut_q <= chan[0].power_cut_fault ? cut_q + 1 : 0;
  end
  // --------------------
  // properties
  // --------------------
  read_unmapped_a: assert property (cmd.valid && !cmd.write && (cmd.addr < 8'h13 || cmd.addr > 8'h15)
    |=> rd_data == 8'h00) else $error("unmapped read not zero");
  grant_gate_a: assert property (power_on_grant[0] |-> $past(power_on_command[0]) &&
    $past(chan[0].discovery_valid) && $past(chan[0].allocation_ok)) else $error("grant without cause");
  high_thresh_a: assert property (power_on_grant[0] && four_pair_wired_bits[0] &&
    chan[0].assigned_class >= PDP_HIGH_CLASS |-> ##[0:2] disconnect_threshold_bits[1:0] == PDP_THRESH_4PAIR_HIGH)
    else $error("threshold not set at turn-on");
  cool_hold_a: assert property (chan[0].cooldown && $past(chan[0].cooldown)
    |-> !detect_start[0] && !class_start[0]) else $error("start during cool-down");
  disc_count_a: assert property ($rose(disconnect_fault_flag[0]) |-> below_q >= DISCONNECT_CYC - 2)
    else $error("disconnect too early");
  flag_off_a: assert property ($rose(disconnect_fault_flag[0]) |-> channel_off[0])
    else $error("flag without turn-off");
  both_off_a: assert property ($rose(disconnect_fault_flag[0]) && $past(four_pair_wired_bits[0])
    && $past(single_signature[0]) |-> channel_off[1]) else $error("partner channel left on");
  cut_count_a: assert property ($rose(power_cut_fault_flag[0]) |-> cut_q >= OVERLOAD_CYC - 1)
    else $error("power-cut flag too early");
  cover property ($rose(disconnect_fault_flag[0]));
  cover property (power_on_grant[0]);
  cover property ($rose(power_cut_fault_flag[0]));
endmodule
bind pdp_ctrl pdp_ctrl_sva #(.DISCONNECT_CYC(DISCONNECT_CYC), .ABOVE_HOLD_CYC(ABOVE_HOLD_CYC),
  .OVERLOAD_CYC(OVERLOAD_CYC)) i_sva (.*);

/* verification/tb_top.sv */
`timescale 1ns/100ps
module tb_top import pdp_pkg::*; ;
  localparam int DC = 20;
  localparam int OC = 10;
  logic clk = 1'b0;
  logic reset = 1'b1;
  pdp_cmd_s cmd;
  logic [7:0] rd_data, thr;
  logic [1:0] fp = 2'h0, ss = 2'h0;
  logic fs = 1'b0;
  logic [3:0] pon = 4'h0, poff = 4'h0, fclr = 4'h0;
  pdp_chan_s [3:0] chan = '0;
  logic [3:0] coff, grant, dst, cst, dflag, cflag;
  int failures = 0, checks_done = 0;
  int offs [2] = '{0, 0};
  int dss = 0;
  always #12.5 clk = ~clk;
  // --------------------
  // design, host and pulse tallies
  // --------------------
  pdp_ctrl #(.DISCONNECT_CYC(DC), .ABOVE_HOLD_CYC(5), .OVERLOAD_CYC(OC)) i_dut (
    .clk(clk), .reset(reset), .cmd(cmd), .rd_data(rd_data), .four_pair_wired_bits(fp), .single_signature(ss),
    .multibit_priority_select(1'b0), .fast_shutdown_input(fs), .power_on_command(pon),
    .power_off_command(poff), .restart_detect(4'h0), .restart_class(4'h0), .fault_clear(fclr), .chan(chan),
    .channel_off(coff), .power_on_grant(grant), .detect_start(dst), .class_start(cst),
    .disconnect_fault_flag(dflag), .power_cut_fault_flag(cflag), .disconnect_threshold_bits(thr));
  pdp_host_model i_host (.clk(clk), .cmd(cmd), .rd_data(rd_data));
  // counted on the falling edge, clear of the registers' update
  always @(negedge clk) begin
    offs[0] += (coff[0] === 1'b1);
    offs[1] += (coff[1] === 1'b1);
    dss += (dst[0] === 1'b1);
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    i_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    i_host.xfer(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic conclude();
    $display("failures %0d checks_done %0d", failures, checks_done);
    if (failures == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // --------------------
  // sequence
  // --------------------
  initial begin
    chan[0].mode = PDP_MODE_MANUAL;
    cyc(6);
    reset <= 1'b0;
    rd(8'h13, 8'h0f);
    rd(8'h14, 8'h00);
    rd(8'h15, 8'h00);
    wr(8'h13, 8'ha5);
    rd(8'h13, 8'ha5);
    wr(8'h20, 8'hff);
    rd(8'h20, 8'h00);
    wr(8'h13, 8'h0f);
    // 4-pair single-signature turn-on, high class
    cyc(1);
    fp <= 2'h1;
    ss <= 2'h1;
    chan[0].discovery_valid <= 1'b1;
    chan[0].allocation_ok <= 1'b1;
    chan[0].assigned_class <= 4'h6;
    pon[0] <= 1'b1;
    cyc(1);
    pon[0] <= 1'b0;
    #1 chk({7'h00, grant[0]}, 8'h01);
    // below run split by a short high
    cyc(1);
    chan[0].powered <= 1'b1;
    chan[1].powered <= 1'b1;
    chan[0].below_threshold <= 1'b1;
    cyc(2);
    #1 chk({6'h00, thr[1:0]}, {6'h00, PDP_THRESH_4PAIR_HIGH});
    cyc(13);
    chan[0].below_threshold <= 1'b0;
    cyc(2);
    chan[0].below_threshold <= 1'b1;
    cyc(3);
    #1 chk(8'(offs[0]), 8'h00);
    cyc(5);
    #1 chk(8'(offs[0]), 8'h01);
    chk(8'(offs[1]), 8'h01);
    chk({7'h00, dflag[0]}, 8'h01);
    cyc(1);
    chan[0].below_threshold <= 1'b0;
    ss <= 2'h0;
    fclr[0] <= 1'b1;
    cyc(1);
    fclr[0] <= 1'b0;
    // supervision off: long below run keeps channel on
    wr(8'h13, 8'h0e);
    cyc(1);
    chan[0].below_threshold <= 1'b1;
    cyc(3 * DC);
    #1 chk(8'(offs[0]), 8'h01);
    cyc(1);
    chan[0].below_threshold <= 1'b0;
    chan[0].powered <= 1'b0;
    // manual discovery, then cool-down hold-off
    wr(8'h14, 8'h01);
    cyc(3);
    #1 chk(8'(dss), 8'h01);
    cyc(1);
    chan[0].detect_done <= 1'b1;
    cyc(1);
    chan[0].detect_done <= 1'b0;
    cyc(2);
    rd(8'h14, 8'h00);
    cyc(1);
    chan[0].cooldown <= 1'b1;
    wr(8'h14, 8'h01);
    cyc(8);
    #1 chk(8'(dss), 8'h01);
    cyc(1);
    chan[0].cooldown <= 1'b0;
    cyc(3);
    #1 chk(8'(dss), 8'h02);
    cyc(1);
    poff[0] <= 1'b1;
    cyc(1);
    poff[0] <= 1'b0;
    rd(8'h14, 8'h00);
    // fast shutdown with priority on channel 0 only
    wr(8'h15, 8'h10);
    cyc(1);
    chan[0].powered <= 1'b1;
    fs <= 1'b1;
    cyc(1);
    fs <= 1'b0;
    cyc(5);
    #1 chk(8'(offs[0]), 8'h02);
    chk(8'(offs[1]), 8'h01);
    // power-cut fault, disable set then cleared
    wr(8'h15, 8'h01);
    cyc(1);
    chan[0].power_cut_fault <= 1'b1;
    cyc(OC + 4);
    #1 chk({7'h00, cflag[0]}, 8'h01);
    chk(8'(offs[0]), 8'h02);
    wr(8'h15, 8'h00);
    cyc(OC - 3);
    #1 chk(8'(offs[0]), 8'h02);
    cyc(8);
    #1 chk(8'(offs[0]), 8'h03);
    conclude();
  end
  // watchdog: the sequence needs about 190 cycles
  initial begin
    #(4000 * 25);
    failures++;
    conclude();
  end
endmodule
